// File: hw/istcr_regs.sv
// configuration and channel 0 readout register bank of the inductive sense device
// Function
// [RL1] channel 0 tracking factor at bits 2-1, resets to 1
// [RL2] channel 0 tracking register at 25h resets to DAh, reserved bits read/write
// [RL3] register 28h holds channel 2 factor at bits 7-6, resets to 50h
// [RL4] register 28h holds channel 1 factor at bits 5-4, resets to 1
// [RL5] register 2Bh holds channel 3 factor at bits 1-0, resets to 01h
// [RL6] channel 3 setup bit 7 selects resistance range, resets to 0
// [RL7] channel 3 setup bits 6-5 select frequency range, resets to 0
// [RL8] channel 3 setup bits 4-0 hold cycle count; register 26h resets to 04h
// [RL9] channel 0 raw result read as bytes at 59h, 5Ah, 5Bh, reset zero
// [RL10] all three raw bytes update together from one conversion
`timescale 1ns/1ps
`include "istcr_params.svh"
module istcr_regs (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire istcr_pkg::istcr_addr_t i_reg_addr,
  input wire logic i_reg_write,
  input wire istcr_pkg::istcr_byte_t i_reg_wdata,
  input wire logic i_reg_read,
  input wire logic i_raw_valid,
  input wire istcr_pkg::istcr_raw_t i_ch0_raw_measurement,
  output istcr_pkg::istcr_byte_t o_reg_rdata,
  output logic o_reg_hit,
  output istcr_pkg::istcr_factor_t o_ch0_track_factor,
  output istcr_pkg::istcr_factor_t o_ch1_track_factor,
  output istcr_pkg::istcr_factor_t o_ch2_track_factor,
  output istcr_pkg::istcr_factor_t o_ch3_track_factor,
  output logic o_ch3_resistance_range,
  output istcr_pkg::istcr_freq_t o_ch3_frequency_range,
  output istcr_pkg::istcr_cycles_t o_ch3_cycle_count
);
  import istcr_pkg::*;

  // ------------------------------------------------
  // address decode
  // ------------------------------------------------
  logic sel_ch0_track;
  logic sel_ch3_setup;
  logic sel_ch12_track;
  logic sel_ch3_track;
  logic [`ISTCR_RAW_BYTES-1:0] sel_raw;
  logic sel_cfg_any;
  logic sel_any;

  assign sel_ch0_track = (i_reg_addr == `ISTCR_OFF_CH0_TRACK);
  assign sel_ch3_setup = (i_reg_addr == `ISTCR_OFF_CH3_SETUP);
  assign sel_ch12_track = (i_reg_addr == `ISTCR_OFF_CH12_TRACK);
  assign sel_ch3_track = (i_reg_addr == `ISTCR_OFF_CH3_TRACK);
  assign sel_raw[0] = (i_reg_addr == `ISTCR_OFF_RAW_LOW);
  assign sel_raw[1] = (i_reg_addr == `ISTCR_OFF_RAW_MID);
  assign sel_raw[2] = (i_reg_addr == `ISTCR_OFF_RAW_HIGH);
  assign sel_cfg_any = sel_ch0_track | sel_ch3_setup | sel_ch12_track | sel_ch3_track;
  assign sel_any = sel_cfg_any | (|sel_raw);

  // ------------------------------------------------
  // write strobes
  // ------------------------------------------------
  // raw bytes and unmapped offsets get no strobe, so such writes fall away
  logic wr_ch0_track;
  logic wr_ch3_setup;
  logic wr_ch12_track;
  logic wr_ch3_track;

  assign wr_ch0_track = i_reg_write & sel_ch0_track;
  assign wr_ch3_setup = i_reg_write & sel_ch3_setup;
  assign wr_ch12_track = i_reg_write & sel_ch12_track;
  assign wr_ch3_track = i_reg_write & sel_ch3_track;

  // ------------------------------------------------
  // next values of the writable registers
  // ------------------------------------------------
  // reserved bits are plain storage, so the whole byte is taken
  istcr_byte_t ch0_track_reg;
  istcr_byte_t ch3_setup_reg;
  istcr_byte_t ch12_track_reg;
  istcr_byte_t ch3_track_reg;
  istcr_byte_t ch0_track_next;
  istcr_byte_t ch3_setup_next;
  istcr_byte_t ch12_track_next;
  istcr_byte_t ch3_track_next;

  assign ch0_track_next = wr_ch0_track ? i_reg_wdata : ch0_track_reg; // RL2
  assign ch3_setup_next = wr_ch3_setup ? i_reg_wdata : ch3_setup_reg; // RL8
  assign ch12_track_next = wr_ch12_track ? i_reg_wdata : ch12_track_reg; // RL3
  assign ch3_track_next = wr_ch3_track ? i_reg_wdata : ch3_track_reg; // RL5

  // ------------------------------------------------
  // channel 0 tracking register
  // ------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ch0_track_reg <= `ISTCR_RST_CH0_TRACK; // RL1 RL2
    end else begin
      ch0_track_reg <= ch0_track_next;
    end
  end

  // ------------------------------------------------
  // channel 3 setup register
  // ------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ch3_setup_reg <= `ISTCR_RST_CH3_SETUP; // RL6 RL7 RL8
    end else begin
      ch3_setup_reg <= ch3_setup_next;
    end
  end

  // ------------------------------------------------
  // channel 1 and 2 tracking register
  // ------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ch12_track_reg <= `ISTCR_RST_CH12_TRACK; // RL3 RL4
    end else begin
      ch12_track_reg <= ch12_track_next;
    end
  end

  // ------------------------------------------------
  // channel 3 tracking register
  // ------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ch3_track_reg <= `ISTCR_RST_CH3_TRACK; // RL5
    end else begin
      ch3_track_reg <= ch3_track_next;
    end
  end

  // ------------------------------------------------
  // channel 0 raw result
  // ------------------------------------------------
  // all 24 bits load on one edge, so the three bytes never mix conversions
  istcr_raw_t raw_value;
  istcr_raw_store u_raw_store (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_load(i_raw_valid), // RL10
    .i_value(i_ch0_raw_measurement),
    .o_value(raw_value)
  );

  // ------------------------------------------------
  // raw byte lanes
  // ------------------------------------------------
  istcr_byte_t raw_masked [`ISTCR_RAW_BYTES];
  istcr_byte_t raw_rdata;

  genvar lane;
  for (lane = 0; lane < `ISTCR_RAW_BYTES; lane++) begin : g_raw_lane
    assign raw_masked[lane] = sel_raw[lane] ? raw_value[lane*`ISTCR_DATA_W +: `ISTCR_DATA_W] :
                              `ISTCR_ZERO_BYTE; // RL9
  end

  // lanes are one-hot selected, so an or merges them
  assign raw_rdata = raw_masked[0] | raw_masked[1] | raw_masked[2];

  // ------------------------------------------------
  // read mux
  // ------------------------------------------------
  istcr_byte_t cfg_rdata;
  istcr_byte_t rdata_next;
  logic hit_next;

  assign cfg_rdata =
    sel_ch0_track ? ch0_track_reg :
    sel_ch3_setup ? ch3_setup_reg :
    sel_ch12_track ? ch12_track_reg :
    sel_ch3_track ? ch3_track_reg :
    `ISTCR_ZERO_BYTE;

  // unmapped offsets read as zero with no hit
  assign rdata_next = i_reg_read ? (cfg_rdata | raw_rdata) : rdata_reg;
  assign hit_next = i_reg_read ? sel_any : hit_reg;

  // ------------------------------------------------
  // read response
  // ------------------------------------------------
  // held until the next read strobe
  istcr_byte_t rdata_reg;
  logic hit_reg;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= `ISTCR_ZERO_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_hit = hit_reg;

  // ------------------------------------------------
  // field outputs, straight from the registers
  // ------------------------------------------------
  assign o_ch0_track_factor = ch0_track_reg[`ISTCR_CH0_TF_HI:`ISTCR_CH0_TF_LO]; // RL1
  assign o_ch2_track_factor = ch12_track_reg[`ISTCR_CH2_TF_HI:`ISTCR_CH2_TF_LO]; // RL3
  assign o_ch1_track_factor = ch12_track_reg[`ISTCR_CH1_TF_HI:`ISTCR_CH1_TF_LO]; // RL4
  assign o_ch3_track_factor = ch3_track_reg[`ISTCR_CH3_TF_HI:`ISTCR_CH3_TF_LO]; // RL5
  assign o_ch3_resistance_range = ch3_setup_reg[`ISTCR_RES_RANGE_BIT]; // RL6
  assign o_ch3_frequency_range = ch3_setup_reg[`ISTCR_FREQ_HI:`ISTCR_FREQ_LO]; // RL7
  assign o_ch3_cycle_count = ch3_setup_reg[`ISTCR_CYC_HI:`ISTCR_CYC_LO]; // RL8
endmodule : istcr_regs

// File: hw/istcr_params.svh
// register offsets, field positions and reset values of the tracking config bank
`ifndef ISTCR_PARAMS_SVH
`define ISTCR_PARAMS_SVH
`define ISTCR_ADDR_W 8
`define ISTCR_DATA_W 8
`define ISTCR_RAW_W 24
`define ISTCR_OFF_CH0_TRACK 8'h25
`define ISTCR_OFF_CH3_SETUP 8'h26
`define ISTCR_OFF_CH12_TRACK 8'h28
`define ISTCR_OFF_CH3_TRACK 8'h2B
`define ISTCR_OFF_RAW_LOW 8'h59
`define ISTCR_OFF_RAW_MID 8'h5A
`define ISTCR_OFF_RAW_HIGH 8'h5B
`define ISTCR_RST_CH0_TRACK 8'hDA
`define ISTCR_RST_CH3_SETUP 8'h04
`define ISTCR_RST_CH12_TRACK 8'h50
`define ISTCR_RST_CH3_TRACK 8'h01
`define ISTCR_RST_RAW 24'h000000
`define ISTCR_CH0_TF_HI 2
`define ISTCR_CH0_TF_LO 1
`define ISTCR_CH2_TF_HI 7
`define ISTCR_CH2_TF_LO 6
`define ISTCR_CH1_TF_HI 5
`define ISTCR_CH1_TF_LO 4
`define ISTCR_CH3_TF_HI 1
`define ISTCR_CH3_TF_LO 0
`define ISTCR_RES_RANGE_BIT 7
`define ISTCR_FREQ_HI 6
`define ISTCR_FREQ_LO 5
`define ISTCR_CYC_HI 4
`define ISTCR_CYC_LO 0
`define ISTCR_RAW_LOW_HI 7
`define ISTCR_RAW_LOW_LO 0
`define ISTCR_RAW_MID_HI 15
`define ISTCR_RAW_MID_LO 8
`define ISTCR_RAW_HIGH_HI 23
`define ISTCR_RAW_HIGH_LO 16
`define ISTCR_ZERO_BYTE 8'h00
`define ISTCR_RAW_BYTES 3
`endif

// File: hw/istcr_pkg.sv
// types of the tracking config bank
package istcr_pkg;
  typedef logic [7:0] istcr_byte_t;
  typedef logic [7:0] istcr_addr_t;
  typedef logic [1:0] istcr_factor_t;
  typedef logic [1:0] istcr_freq_t;
  typedef logic [4:0] istcr_cycles_t;
  typedef logic [23:0] istcr_raw_t;
endpackage : istcr_pkg

// File: hw/istcr_raw_store.sv
// holds the channel 0 raw result, loaded whole in one edge
`timescale 1ns/1ps
`include "istcr_params.svh"
module istcr_raw_store (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire istcr_pkg::istcr_raw_t i_value,
  output istcr_pkg::istcr_raw_t o_value
);
  import istcr_pkg::*;
  istcr_raw_t value_reg;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      value_reg <= `ISTCR_RST_RAW;
    end else if (i_load) begin
      value_reg <= i_value;
    end
  end
  assign o_value = value_reg;
endmodule : istcr_raw_store

// File: test/istcr_regs_properties.sv
// port checker of the tracking config bank
`timescale 1ns/1ps
module istcr_regs_chk (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire istcr_pkg::istcr_addr_t i_reg_addr,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire istcr_pkg::istcr_byte_t i_reg_wdata,
  input wire logic o_reg_hit,
  input wire istcr_pkg::istcr_factor_t o_ch0_track_factor,
  input wire istcr_pkg::istcr_factor_t o_ch1_track_factor,
  input wire istcr_pkg::istcr_factor_t o_ch2_track_factor,
  input wire istcr_pkg::istcr_factor_t o_ch3_track_factor,
  input wire logic o_ch3_resistance_range,
  input wire istcr_pkg::istcr_freq_t o_ch3_frequency_range,
  input wire istcr_pkg::istcr_cycles_t o_ch3_cycle_count
);
  import istcr_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire logic w25 = i_reg_write && i_reg_addr == 8'h25;
  wire logic w26 = i_reg_write && i_reg_addr == 8'h26;
  wire logic w28 = i_reg_write && i_reg_addr == 8'h28;
  wire logic w2b = i_reg_write && i_reg_addr == 8'h2B;
  AST_CH0_SET: assert property (w25 |=> o_ch0_track_factor == $past(i_reg_wdata[2:1])) else $error("ch0 factor");
  AST_CH0_HOLD: assert property (!w25 |=> $stable(o_ch0_track_factor)) else $error("ch0 factor moved");
  AST_CH2_SET: assert property (w28 |=> o_ch2_track_factor == $past(i_reg_wdata[7:6])) else $error("ch2 factor");
  AST_CH1_SET: assert property (w28 |=> o_ch1_track_factor == $past(i_reg_wdata[5:4])) else $error("ch1 factor");
  AST_CH3_SET: assert property (w2b |=> o_ch3_track_factor == $past(i_reg_wdata[1:0])) else $error("ch3 factor");
  AST_RANGE: assert property (w26 |=> o_ch3_resistance_range == $past(i_reg_wdata[7])) else $error("range");
  AST_FREQ: assert property (w26 |=> o_ch3_frequency_range == $past(i_reg_wdata[6:5])) else $error("freq");
  AST_CYCLES: assert property (w26 |=> o_ch3_cycle_count == $past(i_reg_wdata[4:0])) else $error("cycles");
  AST_RAW_HIT: assert property (i_reg_read && i_reg_addr inside {8'h59, 8'h5A, 8'h5B} |=> o_reg_hit) else $error("hit");
endmodule : istcr_regs_chk
bind istcr_regs istcr_regs_chk i_chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
  .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .i_reg_wdata(i_reg_wdata), .o_reg_hit(o_reg_hit),
  .o_ch0_track_factor(o_ch0_track_factor), .o_ch1_track_factor(o_ch1_track_factor),
  .o_ch2_track_factor(o_ch2_track_factor), .o_ch3_track_factor(o_ch3_track_factor),
  .o_ch3_resistance_range(o_ch3_resistance_range), .o_ch3_frequency_range(o_ch3_frequency_range),
  .o_ch3_cycle_count(o_ch3_cycle_count));

// File: test/istcr_host.sv
// host model driving the register strobe port
`timescale 1ns/1ps
module istcr_host (
  input wire logic i_clock,
  input wire istcr_pkg::istcr_byte_t i_rdata,
  output istcr_pkg::istcr_addr_t o_addr,
  output logic o_write,
  output logic o_read,
  output istcr_pkg::istcr_byte_t o_wdata
);
  import istcr_pkg::*;
  initial begin
    o_addr = 8'h00;
    o_write = 1'b0;
    o_read = 1'b0;
    o_wdata = 8'h00;
  end
  // one strobe cycle; released address and data lines show the inverse
  task automatic access(input istcr_addr_t a, input logic wr, input istcr_byte_t d, output istcr_byte_t q);
    @(negedge i_clock);
    o_addr = a;
    o_wdata = d;
    o_write = wr;
    o_read = !wr;
    @(negedge i_clock);
    q = i_rdata;
    o_write = 1'b0;
    o_read = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : access
endmodule : istcr_host

// File: test/tb_istcr_regs.sv
// self-checking bench of the tracking config bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_istcr_regs;
  import istcr_pkg::*;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_raw_valid = 1'b0;
  istcr_raw_t raw = 24'h000000;
  istcr_raw_t e;
  istcr_addr_t a;
  istcr_byte_t wd, rd, q, d, shadow [4];
  logic w, r, hit, rr;
  istcr_factor_t f0, f1, f2, f3;
  istcr_freq_t fr;
  istcr_cycles_t cy;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'hffb0;
  int k;
  always #4 i_clock = ~i_clock;
  istcr_host i_istcr_host (.i_clock(i_clock), .i_rdata(rd), .o_addr(a), .o_write(w), .o_read(r), .o_wdata(wd));
  istcr_regs i_istcr_regs (.i_clock(i_clock), .i_rstn(i_rstn), .i_reg_addr(a), .i_reg_write(w), .i_reg_wdata(wd),
    .i_reg_read(r), .i_raw_valid(i_raw_valid), .i_ch0_raw_measurement(raw), .o_reg_rdata(rd), .o_reg_hit(hit),
    .o_ch0_track_factor(f0), .o_ch1_track_factor(f1), .o_ch2_track_factor(f2), .o_ch3_track_factor(f3),
    .o_ch3_resistance_range(rr), .o_ch3_frequency_range(fr), .o_ch3_cycle_count(cy));
  function automatic istcr_addr_t cfg(input int n);
    return n == 0 ? 8'h25 : n == 1 ? 8'h26 : n == 2 ? 8'h28 : 8'h2B;
  endfunction : cfg
  function automatic istcr_byte_t rst(input int n);
    return n == 0 ? 8'hDA : n == 1 ? 8'h04 : n == 2 ? 8'h50 : 8'h01;
  endfunction : rst
  function automatic logic [15:0] fields();
    return {shadow[0][2:1], shadow[2][5:4], shadow[2][7:6], shadow[3][1:0], shadow[1]};
  endfunction : fields
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    fails++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge i_clock);
    @(negedge i_clock) i_rstn = 1'b1;
    for (k = 0; k < 4; k++) begin
      shadow[k] = rst(k);
      i_istcr_host.access(cfg(k), 1'b0, 8'h00, q);
      `CHK("reset value", {1'b1, rst(k)}, {hit, q})
    end
    `CHK("reset fields", fields(), {f0, f1, f2, f3, rr, fr, cy})
    $display("test reset done");
    for (int j = 0; j < 40; j++) begin
      k = j < 8 ? j % 4 : {$random(seed)} % 4;
      d = j < 8 ? {8{j[2]}} : 8'($random(seed));
      i_istcr_host.access(cfg(k), 1'b1, d, q);
      shadow[k] = d;
      i_istcr_host.access(cfg(k), 1'b0, 8'h00, q);
      `CHK("readback", {1'b1, d}, {hit, q})
      `CHK("fields", fields(), {f0, f1, f2, f3, rr, fr, cy})
    end
    $display("test config done");
    for (int j = 0; j < 4; j++) begin
      e = 24'($random(seed));
      @(negedge i_clock);
      raw = e;
      i_raw_valid = 1'b1;
      @(negedge i_clock);
      raw = ~e;
      i_raw_valid = 1'b0;
      i_istcr_host.access(8'h59, 1'b1, ~e[7:0], q);
      for (int b = 0; b < 3; b++) begin
        i_istcr_host.access(8'(8'h59 + b), 1'b0, 8'h00, q);
        `CHK("raw byte", {1'b1, e[8*b +: 8]}, {hit, q})
      end
      i_istcr_host.access(8'h27, 1'b0, 8'h00, q);
      `CHK("unmapped", 9'h000, {hit, q})
    end
    $display("test raw done");
    summarize();
  end
endmodule : tb_istcr_regs
